// *** hdl/burst_sram_pkg.sv ***
package burst_sram_pkg;
    localparam int ADDR_W = 19;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 36;
    // Lane j is {data[PAR_LSB+j], data[BYTE_W*j +: BYTE_W]}
    localparam int PAR_LSB = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW = 5;
    localparam int SLEEP_CYC = 2;
    localparam logic [3:0] ALL_LANES = 4'hf;
    localparam logic [3:0] NO_LANES = 4'h0;
    localparam logic [1:0] BEAT_ZERO = 2'h0;
    localparam logic [1:0] BEAT_ONE = 2'h1;
    localparam logic MODE_RST = 1'h1;
    localparam logic [SLEEP_CYC-1:0] SLEEP_RST = 2'h0;
    localparam logic [FIFO_AW:0] PTR_RST = 6'h00;
    localparam logic [FIFO_AW:0] READY_LIMIT = 6'h1e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_WRITE = 2'h3,
        ST_SLEEP = 2'h2
    } access_st_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] mask;
    } wr_req_t;

    // Low address bits of a beat: xor for interleaved, add for linear
    function automatic logic [1:0] burst_low(
        input logic [1:0] base,
        input logic [1:0] beat,
        input logic interleave
    );
        burst_low = interleave ? (base ^ beat) : 2'(base + beat);
    endfunction : burst_low
endpackage : burst_sram_pkg

// *** hdl/pipelined_burst_sram.sv ***
// How it works
// [RQ1] All inputs and read data registered on rise
// [RQ2] Read starts on valid strobe, select, no write
// [RQ3] Read data appears after the next rise
// [RQ4] Outputs off in first cycle after selection
// [RQ5] Deselect turns outputs off one rise later
// [RQ6] Processor strobe start ignores write and advance
// [RQ7] Processor strobe write decided at second rise
// [RQ8] Global write stores all four lanes
// [RQ9] Byte writes store only selected lanes
// [RQ10] Controller strobe write completes in one clock
// [RQ11] Any detected write turns drivers off
// [RQ12] Master turns drivers off before driving data
// [RQ13] Start address low bits seed burst counter
// [RQ14] Advance low steps counter, reads and writes
// [RQ15] Burst order sampled from order select input
// [RQ16] Interleaved order xors start with beat
// [RQ17] Linear order counts up modulo four
// [RQ18] Sleep entry and exit take two clocks
// [RQ19] Access pending at sleep entry is dropped
// [RQ20] Master deselects before raising sleep
// [RQ21] Master stays idle two clocks after sleep
// [RQ22] Both strobes low: processor strobe wins while first select is low
// [RQ23] Order select low linear, high interleaved
// [RQ24] Selected only with first low, second high, third low
// [RQ25] Counter wraps to burst start after fourth beat
`timescale 1ns/1ps

module write_fifo #(
    parameter int W = 59,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data,
    output logic [AW:0] o_level
);
    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    wire push = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;

    assign o_level = wp_q - rp_q;
    assign o_in_ready = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
    assign o_out_valid = wp_q != rp_q;
    assign o_out_data = mem[rp_q[AW-1:0]];

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wp_q <= burst_sram_pkg::PTR_RST;
            rp_q <= burst_sram_pkg::PTR_RST;
        end else begin
            wp_q <= push ? wp_q + 1'b1 : wp_q;
            rp_q <= pop ? rp_q + 1'b1 : rp_q;
        end
    end
endmodule : write_fifo

module pipelined_burst_sram (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [18:0] i_addr,
    input wire logic i_processor_address_strobe_n,
    input wire logic i_controller_address_strobe_n,
    input wire logic i_burst_step_n,
    input wire logic i_global_write_n,
    input wire logic i_byte_write_enable_n,
    input wire logic [3:0] i_byte_lane_select_n,
    input wire logic i_chip_select_first_n,
    input wire logic i_chip_select_second,
    input wire logic i_chip_select_third_n,
    input wire logic i_output_enable_n,
    input wire logic i_burst_order,
    input wire logic i_sleep_request,
    input wire logic [35:0] i_data,
    output logic [35:0] o_data,
    output logic o_data_oe_n,
    output logic o_write_ready,
    output logic o_sleeping
);
    burst_sram_pkg::access_st_t st_q;
    burst_sram_pkg::access_st_t st_d;
    logic [35:0] mem [0:(1<<19)-1];
    logic [16:0] upper_q;
    logic [1:0] base_q;
    logic [1:0] cnt_q;
    logic mode_q;
    logic [1:0] sleep_q;
    logic [35:0] data_q;
    logic oe_n_q;
    logic ready_q;
    burst_sram_pkg::wr_req_t push_req;
    burst_sram_pkg::wr_req_t drain_req;
    logic drain_valid;
    logic fifo_ready;
    logic [5:0] fifo_level;

    // Select and strobe decode
    // [RQ24] select combination
    wire cs_ok = !i_chip_select_first_n & i_chip_select_second & !i_chip_select_third_n;
    wire proc_strobe_v = !i_processor_address_strobe_n & !i_chip_select_first_n;
    // [RQ22] processor strobe priority
    wire ctrl_strobe_v = !i_controller_address_strobe_n & !proc_strobe_v;
    wire strobe = proc_strobe_v | ctrl_strobe_v;
    wire asleep = sleep_q[1];
    wire start_sel = strobe & cs_ok & !asleep;
    wire desel = strobe & !cs_ok;
    wire active = (st_q == burst_sram_pkg::ST_READ) | (st_q == burst_sram_pkg::ST_WRITE);
    wire cont = !strobe & active & !asleep;

    // Write control decode
    // [RQ8] global write forces all lanes
    // [RQ9] byte enable gates lane selects
    wire [3:0] lane_mask = !i_global_write_n ? burst_sram_pkg::ALL_LANES :
        (!i_byte_write_enable_n ? ~i_byte_lane_select_n : burst_sram_pkg::NO_LANES);
    wire wr_ctl = lane_mask != burst_sram_pkg::NO_LANES;
    // [RQ6] processor start never writes
    // [RQ7] second rise decides the write
    // [RQ10] controller write in one clock
    wire write_now = (start_sel & ctrl_strobe_v & wr_ctl) | (cont & wr_ctl);
    // [RQ2] read start condition
    wire read_next = (start_sel & !(ctrl_strobe_v & wr_ctl)) | (cont & !wr_ctl);

    // Burst counter
    // [RQ14] advance steps the beat
    wire [1:0] cnt_nx = !i_burst_step_n ? 2'(cnt_q + burst_sram_pkg::BEAT_ONE) : cnt_q;
    // [RQ16] [RQ17] order applied to beat
    wire [1:0] cur_low = burst_sram_pkg::burst_low(base_q, cnt_q, mode_q);
    wire [1:0] nx_low = burst_sram_pkg::burst_low(base_q, cnt_nx, mode_q);
    wire [18:0] cur_addr = {upper_q, cur_low};
    wire [18:0] wr_addr = start_sel ? i_addr : {upper_q, nx_low};

    assign st_d = asleep ? burst_sram_pkg::ST_SLEEP :
        write_now ? burst_sram_pkg::ST_WRITE :
        read_next ? burst_sram_pkg::ST_READ : burst_sram_pkg::ST_IDLE;

    // [RQ3] [RQ4] [RQ5] drive only for a read issued a rise earlier
    // [RQ11] a write at this rise forces drivers off
    wire oe_n_d = !((st_q == burst_sram_pkg::ST_READ) & !write_now & !i_output_enable_n & !asleep);

    assign push_req.addr = wr_addr;
    assign push_req.data = i_data;
    assign push_req.mask = lane_mask;

    write_fifo #(
        .W($bits(burst_sram_pkg::wr_req_t)),
        .DEPTH(burst_sram_pkg::FIFO_DEPTH),
        .AW(burst_sram_pkg::FIFO_AW)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_valid(write_now),
        .o_in_ready(fifo_ready),
        .i_in_data(push_req),
        .o_out_valid(drain_valid),
        .i_out_ready(!asleep),
        .o_out_data(drain_req),
        .o_level(fifo_level)
    );

    // Self-timed core write, stalled while asleep
    always_ff @(posedge i_mclk) begin
        if (drain_valid && !asleep) begin
            for (int j = 0; j < burst_sram_pkg::LANES; j++) begin
                if (drain_req.mask[j]) begin
                    mem[drain_req.addr][8*j +: 8] <= drain_req.data[8*j +: 8];
                    mem[drain_req.addr][burst_sram_pkg::PAR_LSB+j] <= drain_req.data[burst_sram_pkg::PAR_LSB+j];
                end
            end
        end
    end

    // [RQ1] output register
    always_ff @(posedge i_mclk) begin
        data_q <= mem[cur_addr];
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_q <= burst_sram_pkg::ST_IDLE;
            oe_n_q <= 1'b1;
            ready_q <= 1'b0;
            mode_q <= burst_sram_pkg::MODE_RST;
            sleep_q <= burst_sram_pkg::SLEEP_RST;
        end else begin
            // [RQ19] sleep forces the access state away
            st_q <= st_d;
            oe_n_q <= oe_n_d;
            ready_q <= fifo_level < burst_sram_pkg::READY_LIMIT;
            // [RQ15] [RQ23] order select sampled
            mode_q <= i_burst_order;
            // [RQ18] two-rise sleep entry and exit
            sleep_q <= {sleep_q[0], i_sleep_request};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            upper_q <= 17'h00000;
            base_q <= burst_sram_pkg::BEAT_ZERO;
            cnt_q <= burst_sram_pkg::BEAT_ZERO;
        end else if (start_sel) begin
            // [RQ13] seed counter from start address
            upper_q <= i_addr[18:2];
            base_q <= i_addr[1:0];
            cnt_q <= burst_sram_pkg::BEAT_ZERO;
        end else if (cont) begin
            // [RQ25] two-bit beat wraps to start
            cnt_q <= cnt_nx;
        end
    end

    assign o_data = data_q;
    assign o_data_oe_n = oe_n_q;
    assign o_write_ready = ready_q;
    assign o_sleeping = sleep_q[1];

    // [RQ3] read data one rise later
    read_latency_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ3]
        (start_sel && proc_strobe_v) ##1 (!strobe && !wr_ctl && !i_output_enable_n && !asleep) |=> !o_data_oe_n)
        else $error("read data not driven one rise after start");

    // [RQ11] write forces drivers off
    write_hiz_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ11]
        write_now |=> o_data_oe_n)
        else $error("drivers on after write");

    // [RQ5] deselect keeps drive one cycle
    dcd_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ5]
        (st_q == burst_sram_pkg::ST_READ && desel && !asleep && !i_output_enable_n)
        |=> !o_data_oe_n ##1 o_data_oe_n)
        else $error("double cycle deselect broken");

    // [RQ4] emerging access starts off
    emerge_hiz_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ4]
        (st_q == burst_sram_pkg::ST_IDLE && start_sel) |=> o_data_oe_n)
        else $error("drivers on in first cycle");

    // [RQ8] global write mask
    global_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ8]
        (write_now && !i_global_write_n) |-> push_req.mask == burst_sram_pkg::ALL_LANES)
        else $error("global write not all lanes");

    // [RQ9] byte lane mask
    lane_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ9]
        (write_now && i_global_write_n) |-> push_req.mask == ~i_byte_lane_select_n)
        else $error("byte lanes wrong");

    // [RQ6] processor start ignores writes
    proc_first_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ6]
        (start_sel && proc_strobe_v) |-> !write_now ##1 (st_q == burst_sram_pkg::ST_READ))
        else $error("write taken on processor start");

    // [RQ25] wrap after four steps
    burst_wrap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ25]
        start_sel ##1 (cont && !i_burst_step_n)[*4] |=> cur_low == base_q)
        else $error("burst did not wrap");

    // [RQ17] linear step
    linear_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ17]
        (cont && !i_burst_step_n && !mode_q && !i_burst_order) |=> cur_low == 2'($past(cur_low) + 2'h1))
        else $error("linear step wrong");

    // [RQ16] interleaved step
    inter_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ16]
        (cont && !i_burst_step_n && mode_q && i_burst_order)
        |=> (cur_low ^ base_q) == 2'(($past(cur_low) ^ $past(base_q)) + 2'h1))
        else $error("interleaved step wrong");

    // [RQ18] sleep entry timing
    sleep_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ18]
        $rose(i_sleep_request) ##1 i_sleep_request |-> !o_sleeping ##1 o_sleeping)
        else $error("sleep entry not two clocks");

    // [RQ19] sleep drops the access
    sleep_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ19]
        asleep |=> (st_q == burst_sram_pkg::ST_SLEEP) && o_data_oe_n)
        else $error("access kept in sleep");

    // [RQ18] sleep exit timing
    sleep_exit_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ18]
        $fell(i_sleep_request) ##1 !i_sleep_request |-> o_sleeping ##1 !o_sleeping)
        else $error("sleep exit not two clocks");

    // [RQ13] start seeds burst counter
    burst_seed_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ13]
        start_sel |=> cur_low == $past(i_addr[1:0]))
        else $error("burst start not seeded");

    // [RQ10] ready flag leaves room
    write_room_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ10]
        o_write_ready |-> fifo_ready)
        else $error("write ready with queue full");
endmodule : pipelined_burst_sram

// *** tb/bus_master_model.sv ***
`timescale 1ns/1ps

module bus_master_model (
    input wire logic i_mclk,
    output logic [18:0] o_addr,
    output logic [3:0] o_ctl,
    output logic [5:0] o_wr,
    output logic [2:0] o_sel,
    output logic o_out_en_n,
    output logic [35:0] o_data
);
    logic oe_prev = 1'b1;

    initial begin
        {o_addr, o_ctl, o_wr, o_sel, o_out_en_n, o_data} = {19'h0, 4'he, 6'h3f, 3'h4, 1'b1, 36'h0};
    end

    // Fields: ctl {proc_n, ctrl_n, step_n, sleep}, wr {glob_n, byte_n, lanes_n}, sel {first_n, second, third_n}
    task automatic cyc(input logic [3:0] ctl, input logic [5:0] wr, input logic [2:0] sel, input logic oe_n,
                       input logic [18:0] addr, input logic [35:0] data);
        @(posedge i_mclk);
        {o_ctl, o_wr, o_sel, o_out_en_n, o_addr} <= {ctl, wr, sel, oe_n, addr};
        o_data <= (oe_n && oe_prev) ? data : ~o_data;
        oe_prev = oe_n;
    endtask : cyc
endmodule : bus_master_model

// *** tb/pipelined_burst_sram_access_logic_test.sv ***
`timescale 1ns/1ps

module pipelined_burst_sram_access_logic_test;
    typedef struct packed {logic [18:0] a; logic [5:0] wr; logic [35:0] d;} wr_row_t;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic order = 1'b1;
    logic [18:0] addr;
    logic [3:0] ctl;
    logic [5:0] wr;
    logic [2:0] sel;
    logic oe_n, d_oe_n, w_ready, asleep;
    logic [35:0] m_data, d_out, bus;
    logic [35:0] mem [int];
    int n_errors = 0;
    int num_checks = 0;
    wr_row_t rows [6] = '{
        '{19'h00010, 6'h1f, 36'h1_1111_1111},
        '{19'h00011, 6'h0e, 36'h2_2222_2222},
        '{19'h00012, 6'h1f, 36'h4_4444_4444},
        '{19'h00013, 6'h1f, 36'h8_8888_8888},
        '{19'h00010, 6'h2e, 36'hf_aaaa_aaaa},
        '{19'h00012, 6'h29, 36'hf_bbbb_bbbb}
    };

    assign bus = (d_oe_n === 1'b0) ? d_out : m_data;

    bus_master_model m_u (.i_mclk(i_mclk), .o_addr(addr), .o_ctl(ctl), .o_wr(wr), .o_sel(sel),
        .o_out_en_n(oe_n), .o_data(m_data));

    pipelined_burst_sram dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr),
        .i_processor_address_strobe_n(ctl[3]), .i_controller_address_strobe_n(ctl[2]),
        .i_burst_step_n(ctl[1]), .i_global_write_n(wr[5]), .i_byte_write_enable_n(wr[4]),
        .i_byte_lane_select_n(wr[3:0]), .i_chip_select_first_n(sel[2]), .i_chip_select_second(sel[1]),
        .i_chip_select_third_n(sel[0]), .i_output_enable_n(oe_n), .i_burst_order(order),
        .i_sleep_request(ctl[0]), .i_data(bus), .o_data(d_out), .o_data_oe_n(d_oe_n),
        .o_write_ready(w_ready), .o_sleeping(asleep));

    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [35:0] merge(input logic [35:0] old, input logic [5:0] w, input logic [35:0] d);
        logic [35:0] r;
        r = old;
        for (int j = 0; j < 4; j++) begin
            if (!w[5] || (!w[4] && !w[j])) begin
                r[8*j +: 8] = d[8*j +: 8];
                r[32+j] = d[32+j];
            end
        end
        return r;
    endfunction : merge

    task automatic idle(input int n, input logic o);
        repeat (n) m_u.cyc(4'he, 6'h3f, 3'h4, o, 19'h0, 36'h0);
    endtask : idle

    task automatic store(input logic [18:0] a, input logic [5:0] w, input logic [35:0] d);
        mem[a] = merge(mem.exists(a) ? mem[a] : 36'h0, w, d);
    endtask : store

    // Deselect, read of n beats from a, then a deselect; odd a starts on processor strobe
    task automatic burst(input logic [18:0] a, input int n);
        logic [1:0] low;
        m_u.cyc(4'ha, 6'h3f, 3'h4, 1'b1, a, 36'h0);
        m_u.cyc(a[0] ? 4'h6 : 4'ha, 6'h3f, 3'h2, 1'b0, a, 36'h0);
        for (int k = 0; k <= n; k++) begin
            m_u.cyc(k < n ? 4'hc : 4'he, 6'h3f, 3'h4, 1'b0, 19'h0, 36'h0);
            low = order ? (a[1:0] ^ 2'(k - 1)) : 2'(a[1:0] + 2'(k - 1));
            #1 if (k == 0) check("first cycle oe_n", 36'h1, 36'(d_oe_n));
            else check("read data", mem[{a[18:2], low}], d_out);
        end
        m_u.cyc(4'ha, 6'h3f, 3'h4, 1'b0, a, 36'h0);
        idle(1, 1'b0);
        #1 check("oe_n after deselect", 36'h0, 36'(d_oe_n));
        idle(1, 1'b1);
        #1 check("oe_n one later", 36'h1, 36'(d_oe_n));
    endtask : burst

    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        idle(2, 1'b1);
        #1 check("ready after reset", 36'h6, 36'({w_ready, d_oe_n, asleep}));
        foreach (rows[i]) begin
            idle(1, 1'b1);
            m_u.cyc(4'ha, rows[i].wr, 3'h2, 1'b1, rows[i].a, rows[i].d);
            idle(1, 1'b1);
            #1 check("oe_n on write", 36'h1, 36'(d_oe_n));
            store(rows[i].a, rows[i].wr, rows[i].d);
        end
        idle(3, 1'b1);
        for (int i = 0; i < 4; i++) burst(19'h00010 + 19'(i), 1);
        for (int o = 1; o >= 0; o--) begin
            @(posedge i_mclk) order <= 1'(o);
            burst(o ? 19'h00011 : 19'h00013, 5);
        end
        for (int i = 0; i < 3; i++) begin
            m_u.cyc(4'ha, 6'h3f, i == 0 ? 3'h0 : (i == 1 ? 3'h3 : 3'h6), 1'b0, 19'h00010, 36'h0);
            idle(2, 1'b0);
            #1 check("unselected oe_n", 36'h1, 36'(d_oe_n));
        end
        idle(1, 1'b1);
        m_u.cyc(4'h2, 6'h00, 3'h2, 1'b1, 19'h00011, 36'h0);
        m_u.cyc(4'he, 6'h2d, 3'h4, 1'b1, 19'h0, 36'h5_5555_5555);
        store(19'h00011, 6'h2d, 36'h5_5555_5555);
        idle(3, 1'b1);
        burst(19'h00011, 1);
        for (int k = 0; k < 6; k++) begin
            m_u.cyc(k < 3 ? 4'hf : 4'he, 6'h3f, 3'h4, 1'b1, 19'h0, 36'h0);
            #1 if (k > 0) check("sleeping", 36'(k >= 2 && k <= 4), 36'(asleep));
        end
        idle(2, 1'b1);
        burst(19'h00012, 1);
        stop_test();
    end

    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
endmodule : pipelined_burst_sram_access_logic_test
